//--- src/wdtsup_pkg.sv
// constants and types shared by the watchdog supervisor files
//
// Contract
// - timeout is 2^prescale times 512 crystal periods; prescale sits in bits 7..4
// - with select bit 3 set, expiry raises an interrupt instead of reset; the code still resets on prescale codes 1000 and up
// - watchdog interrupt ignores the global interrupt allow bit
// - watchdog interrupt is always serviced at the fixed high priority
// - with interrupt response, the watchdog works as a periodic prescaled timer
// - status flag bit 2 sets on every watchdog timeout
// - status clears only by software zero or hardware reset, not watchdog reset
// - writing one to arm bit 1 enables and restarts the counter
// - software must re-arm within each period, else reset or interrupt follows
// - arm clears on zero write, watchdog reset, hardware reset, supply-monitor interrupt
// - register write takes effect only right after an instruction set unlock bit 0
package wdtsup_pkg;

	localparam int         CTRL_W          = 8;
	localparam int         PRE_LSB         = 4;
	localparam int         PRE_W           = 4;
	localparam int         INT_SEL_BIT     = 3;
	localparam int         STATUS_BIT      = 2;
	localparam int         ARM_BIT         = 1;
	localparam int         UNLOCK_BIT      = 0;
	localparam logic [7:0] CTRL_RESET      = 8'h00;
	localparam int         XTAL_HZ         = 32768;
	localparam int         BASE_TICKS_LOG2 = 9;
	localparam logic [3:0] PRE_IMMEDIATE   = 4'h8;
	localparam int         CNT_W           = BASE_TICKS_LOG2 + 8;

	typedef struct packed
	{
		logic [PRE_W-1:0] prescale;
		logic             int_sel;
		logic             status;
		logic             arm;
		logic             unlock;
	} wdtsup_ctrl_t;

	typedef struct packed
	{
		logic        wr;
		logic [7:0]  wdata;
		logic        instr_end;
	} wdtsup_sfr_t;

	typedef enum
	{
		ST_OFF,
		ST_COUNT,
		ST_FIRE
	} wdtsup_state_t;

endpackage

//--- src/wdtsup_tick_counter.sv
// crystal tick counter with programmable terminal count
`timescale 1ns/1ps
`default_nettype none

module wdtsup_tick_counter #(
	parameter int W = 17
)
(
	// clock and reset
	input  wire logic         clock,
	input  wire logic         resetn,
	// control
	input  wire logic         clear,
	input  wire logic         tick,
	input  wire logic [W-1:0] limit,
	// result
	output var  logic         done_reg
);

	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	logic         last;
	logic         done_next;

	assign last       = (count_reg == (limit - W'(1)));
	assign count_next = clear ? '0 : (tick ? (last ? '0 : count_reg + W'(1)) : count_reg);
	assign done_next  = tick & last & ~clear;

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			count_reg <= '0;
			done_reg  <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			done_reg  <= done_next;
		end
	end

endmodule

`default_nettype wire

//--- src/wdtsup_supervisor.sv
// watchdog supervisor: control register, timeout counter, reset and interrupt requests
`timescale 1ns/1ps
`default_nettype none

module wdtsup_supervisor
	import wdtsup_pkg::*;
(
	// clock and hardware reset
	input  wire logic                    clock,
	input  wire logic                    resetn,
	// special-function register access from the core
	input  wire wdtsup_pkg::wdtsup_sfr_t sfr,
	output var  logic [7:0]              sfr_rdata_reg,
	// crystal clock pin, sampled
	input  wire logic                    xtal_in,
	// supply monitor interrupt event
	input  wire logic                    supply_monitor_irq,
	// interrupt acknowledge from the core
	input  wire logic                    irq_ack,
	// requests to the core
	output var  logic                    wd_reset_req_reg,
	output var  logic                    wd_irq_req_reg,
	output var  logic                    wd_irq_high_prio_reg
);

	import wdtsup_pkg::*;

	// crystal synchroniser; first stage only feeds the second
	logic xtal_s1_reg;
	logic xtal_s2_reg;
	logic xtal_s3_reg;
	logic xtal_tick;

	// control register image
	wdtsup_ctrl_t ctrl_reg;
	wdtsup_ctrl_t ctrl_next;
	logic         unlock_pend_reg;
	logic         unlock_pend_next;

	// state
	wdtsup_state_t state_reg;
	wdtsup_state_t state_next;

	// decoded terms
	logic             wr_ok;
	logic             wr_locked_unlock;
	logic             arm_write;
	logic             sw_clear_status;
	logic             immediate;
	logic             imm_code;
	logic             fire;
	logic             fire_reset;
	logic             fire_irq;
	logic             cnt_clear;
	logic             cnt_done;
	logic [CNT_W-1:0] cnt_limit;
	logic             irq_next;

	assign xtal_tick = xtal_s2_reg & ~xtal_s3_reg;

	// a locked write can only raise the unlock bit; other bits are ignored
	assign wr_ok            = sfr.wr & ctrl_reg.unlock;
	assign wr_locked_unlock = sfr.wr & ~ctrl_reg.unlock & sfr.wdata[UNLOCK_BIT];

	// unlock lives through the next instruction only, then drops
	assign unlock_pend_next = sfr.instr_end ? 1'b0 :
		(unlock_pend_reg | wr_locked_unlock);

	assign arm_write       = wr_ok & sfr.wdata[ARM_BIT];
	assign sw_clear_status = wr_ok & ~sfr.wdata[STATUS_BIT];

	// reserved codes above 1000 behave like 1000 here
	assign imm_code  = (ctrl_reg.prescale >= PRE_IMMEDIATE);

	// the zero-length period always resets, even with interrupt response selected
	assign immediate = ctrl_reg.arm & imm_code;

	// period is 2^(prescale+9) crystal ticks; only codes 0..7 reach this
	assign cnt_limit = CNT_W'(1) << (CNT_W'(ctrl_reg.prescale[2:0])
		+ CNT_W'(BASE_TICKS_LOG2));

	assign fire       = (state_reg == ST_FIRE);
	assign fire_reset = fire & (~ctrl_reg.int_sel | imm_code);
	assign fire_irq   = fire & ctrl_reg.int_sel & ~imm_code;

	// a refresh or any leave from counting restarts the period from zero
	assign cnt_clear = arm_write | (state_reg != ST_COUNT);

	wdtsup_tick_counter #(
		.W (CNT_W)
	)
	wdtsup_tick_counter_inst
	(
		.clock    (clock),
		.resetn   (resetn),
		.clear    (cnt_clear),
		.tick     (xtal_tick),
		.limit    (cnt_limit),
		.done_reg (cnt_done)
	);

	// next control image
	always_comb
	begin
		ctrl_next = ctrl_reg;
		if (wr_ok)
		begin
			ctrl_next.prescale = sfr.wdata[PRE_LSB +: PRE_W];
			ctrl_next.int_sel  = sfr.wdata[INT_SEL_BIT];
			ctrl_next.arm      = sfr.wdata[ARM_BIT];
		end
		if (sfr.instr_end)
		begin
			ctrl_next.unlock = unlock_pend_reg | wr_locked_unlock;
		end
		// timeout wins over a software clear in the same cycle
		ctrl_next.status = fire | (ctrl_reg.status & ~sw_clear_status);
		if (fire_reset | supply_monitor_irq)
		begin
			ctrl_next.arm = 1'b0;
		end
	end

	// sequencing of counting and expiry
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_OFF:
			begin
				if (ctrl_reg.arm)
				begin
					state_next = ST_COUNT;
				end
			end
			ST_COUNT:
			begin
				if (!ctrl_reg.arm)
				begin
					state_next = ST_OFF;
				end
				else if (immediate | (cnt_done & ~arm_write))
				begin
					state_next = ST_FIRE;
				end
			end
			ST_FIRE:
			begin
				// interrupt response keeps running as a periodic timer
				state_next = fire_irq ? ST_COUNT : ST_OFF;
			end
			default:
			begin
				state_next = ST_OFF;
			end
		endcase
	end

	// the request goes out on a dedicated line that the allow bit never gates
	assign irq_next = fire_irq | (wd_irq_req_reg & ~irq_ack);

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			xtal_s1_reg <= 1'b0;
			xtal_s2_reg <= 1'b0;
			xtal_s3_reg <= 1'b0;
		end
		else
		begin
			xtal_s1_reg <= xtal_in;
			xtal_s2_reg <= xtal_s1_reg;
			xtal_s3_reg <= xtal_s2_reg;
		end
	end

	// hardware reset is the only reset that clears the status flag
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			ctrl_reg        <= wdtsup_ctrl_t'(CTRL_RESET);
			unlock_pend_reg <= 1'b0;
			state_reg       <= ST_OFF;
		end
		else
		begin
			ctrl_reg        <= ctrl_next;
			unlock_pend_reg <= unlock_pend_next;
			state_reg       <= state_next;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			wd_reset_req_reg     <= 1'b0;
			wd_irq_req_reg       <= 1'b0;
			wd_irq_high_prio_reg <= 1'b0;
		end
		else
		begin
			wd_reset_req_reg     <= fire_reset;
			wd_irq_req_reg       <= irq_next;
			wd_irq_high_prio_reg <= irq_next;
		end
	end

	// readback follows the image the control register takes at this same edge
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			sfr_rdata_reg <= CTRL_RESET;
		end
		else
		begin
			sfr_rdata_reg <= ctrl_next;
		end
	end

endmodule

`default_nettype wire

//--- verif/wdtsup_assertions.sv
// port-level assertions for the watchdog supervisor
`timescale 1ns/1ps
`default_nettype none

module wdtsup_assertions
	import wdtsup_pkg::*;
(
	// clock and reset
	input wire logic                    clock,
	input wire logic                    resetn,
	// core side
	input wire wdtsup_pkg::wdtsup_sfr_t sfr,
	input wire logic [7:0]              sfr_rdata_reg,
	input wire logic                    xtal_in,
	input wire logic                    supply_monitor_irq,
	input wire logic                    irq_ack,
	// requests
	input wire logic                    wd_reset_req_reg,
	input wire logic                    wd_irq_req_reg,
	input wire logic                    wd_irq_high_prio_reg
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_prio; wd_irq_high_prio_reg == wd_irq_req_reg; endproperty
	a_prio: assert property (p_prio) else $error("priority marker differs");
	property p_lock; sfr.wr && !sfr_rdata_reg[0] |=> $stable(sfr_rdata_reg[7:3]); endproperty
	a_lock: assert property (p_lock) else $error("locked write changed control");
	property p_unl;
		sfr.wr && sfr_rdata_reg[0] |=> sfr_rdata_reg[7:3] == $past(sfr.wdata[7:3]);
	endproperty
	a_unl: assert property (p_unl) else $error("unlocked write not taken");
	property p_stset; wd_reset_req_reg || $rose(wd_irq_req_reg) |-> sfr_rdata_reg[2]; endproperty
	a_stset: assert property (p_stset) else $error("status not set on timeout");
	property p_stkeep;
		sfr_rdata_reg[2] && !(sfr.wr && sfr_rdata_reg[0]) |=> sfr_rdata_reg[2];
	endproperty
	a_stkeep: assert property (p_stkeep) else $error("status lost");
	property p_armrst; wd_reset_req_reg |-> ##[0:1] !sfr_rdata_reg[1]; endproperty
	a_armrst: assert property (p_armrst) else $error("arm kept after reset request");
	property p_psm; supply_monitor_irq |=> !sfr_rdata_reg[1]; endproperty
	a_psm: assert property (p_psm) else $error("arm kept after supply event");
	property p_hold; wd_irq_req_reg && !irq_ack |=> wd_irq_req_reg; endproperty
	a_hold: assert property (p_hold) else $error("interrupt dropped unacknowledged");
	property p_pulse;
		wd_reset_req_reg |-> (!sfr_rdata_reg[3] || sfr_rdata_reg[7]) ##1 !wd_reset_req_reg;
	endproperty
	a_pulse: assert property (p_pulse) else $error("reset request wrong");
	property p_immirq; $rose(wd_irq_req_reg) |-> !sfr_rdata_reg[7]; endproperty
	a_immirq: assert property (p_immirq) else $error("interrupt on immediate code");
endmodule

`default_nettype wire

//--- verif/test_watchdog_supervisor.sv
// self-checking bench for the watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
	$display("unexpected %s exp %h got %h", nm, e, a); end end

module test_watchdog_supervisor;
	import wdtsup_pkg::*;
	logic        clock = 0;
	logic        resetn = 0;
	logic        xtal_in = 0;
	logic        supply_monitor_irq = 0;
	logic        irq_ack = 0;
	wdtsup_sfr_t sfr = '0;
	logic [7:0]  sfr_rdata_reg;
	logic        wd_reset_req_reg;
	logic        wd_irq_req_reg;
	logic        wd_irq_high_prio_reg;
	int          fail_count = 0;
	int          checks = 0;
	int          rst_seen = 0;
	int          n;
	always #2.5 clock = ~clock;
	// fast crystal, one tick per 8 cycles, keeps periods short
	always #20 xtal_in = ~xtal_in;
	always @(negedge clock) if (wd_reset_req_reg === 1'b1) rst_seen++;
	wdtsup_supervisor wdtsup_supervisor_inst (.clock, .resetn, .sfr, .sfr_rdata_reg, .xtal_in,
		.supply_monitor_irq, .irq_ack, .wd_reset_req_reg, .wd_irq_req_reg, .wd_irq_high_prio_reg);
	task end_of_test;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ul adds the unlock instruction right in front of the write, nothing between
	task wr(input logic [7:0] d, input bit ul);
		if (ul)
		begin
			sfr = '{1'b1, 8'h01, 1'b1};
			@(negedge clock);
		end
		sfr = '{1'b1, d, 1'b1};
		@(negedge clock);
		sfr = '0;
		// idle cycle so back-to-back calls never retouch sfr in one time step
		@(negedge clock);
	endtask
	task wt(input bit irq, input int lim);
		n = 0;
		while (n < lim && (irq ? wd_irq_req_reg : wd_reset_req_reg) !== 1'b1)
		begin
			@(negedge clock);
			n++;
		end
		if (n == lim)
		begin
			fail_count++;
			$display("unexpected request exp 1 got 0");
			end_of_test;
		end
	endtask
	task t_lock;
		`CHK("reset value", 8'h00, sfr_rdata_reg)
		wr(8'h72, 0);
		`CHK("locked", 8'h00, sfr_rdata_reg)
		wr(8'h70, 1);
		`CHK("unlocked", 8'h70, sfr_rdata_reg)
		wr(8'h02, 0);
		`CHK("relocked", 8'h70, sfr_rdata_reg)
		$display("lock test done");
	endtask
	task t_timeout;
		wr(8'h02, 1);
		repeat (3)
		begin
			repeat (3000) @(negedge clock);
			wr(8'h02, 1);
		end
		`CHK("refresh", 0, rst_seen)
		wt(0, 5000);
		`CHK("period", 1'b1, n >= 4088 && n <= 4120)
		@(negedge clock);
		`CHK("status arm", 2'b10, sfr_rdata_reg[2:1])
		wr(8'h00, 1);
		`CHK("cleared", 8'h00, sfr_rdata_reg)
		wr(8'h82, 1);
		wt(0, 12);
		`CHK("status", 1'b1, sfr_rdata_reg[2])
		wr(8'h8a, 1);
		wt(0, 12);
		`CHK("immediate irq", 1'b0, wd_irq_req_reg)
		`CHK("immediate ctrl", 8'h8c, sfr_rdata_reg)
		$display("timeout test done");
	endtask
	task t_irq;
		wr(8'h1a, 1);
		wt(1, 8400);
		`CHK("irq period", 1'b1, n >= 8180 && n <= 8230)
		`CHK("prio", 1'b1, wd_irq_high_prio_reg)
		repeat (4) @(negedge clock);
		`CHK("held", 1'b1, wd_irq_req_reg)
		irq_ack = 1;
		@(negedge clock);
		irq_ack = 0;
		@(negedge clock);
		`CHK("acked", 1'b0, wd_irq_req_reg)
		wt(1, 8400);
		`CHK("periodic", 1'b1, n >= 8170 && n <= 8230)
		`CHK("armed", 1'b1, sfr_rdata_reg[1])
		supply_monitor_irq = 1;
		@(negedge clock);
		supply_monitor_irq = 0;
		@(negedge clock);
		`CHK("supply arm", 1'b0, sfr_rdata_reg[1])
		resetn = 0;
		repeat (2) @(negedge clock);
		resetn = 1;
		`CHK("hw reset", 8'h00, sfr_rdata_reg)
		$display("interrupt test done");
	endtask
	initial
	begin
		repeat (2) @(negedge clock);
		resetn = 1;
		t_lock;
		t_timeout;
		t_irq;
		end_of_test;
	end
endmodule

bind wdtsup_supervisor wdtsup_assertions wdtsup_assertions_inst (.clock, .resetn, .sfr,
	.sfr_rdata_reg, .xtal_in, .supply_monitor_irq, .irq_ack, .wd_reset_req_reg,
	.wd_irq_req_reg, .wd_irq_high_prio_reg);

`default_nettype wire
